// ===== spm_top.sv
/*
  shared pin function, clock output, compare output and reset control,
  with an axi4-lite register slave.
  assumes aresetn is the power-on reset and reset_input_pin_n the general
  reset, both synchronous to aclk; peripheral signals come from units outside.
*/
`default_nettype none
`include "spm_params.svh"
module spm_top
  import spm_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_input_pin_n,
  input wire logic power_drive_protect_input_n,
  input wire logic [12:0] shared_pin_in,
  output logic [12:0] shared_pin_out,
  output logic [12:0] shared_pin_oe,
  input wire logic [12:0] periph_out,
  input wire logic [12:0] periph_oe,
  output logic [12:0] periph_in,
  output logic [1:0] quadrature_encoder_input,
  input wire logic [3:0] clock_sources,
  input wire logic branch_poll,
  output logic branch_taken,
  output logic branch_done,
  input wire logic fetch_advance,
  output logic [PC_W-1:0] fetch_addr,
  output logic fetch_en,
  input wire logic [5:0] compare_level,
  output logic [5:0] full_compare_output,
  output logic [5:0] full_compare_oe
);
  localparam int NP = `SPM_NPIN;

  // the pc register is read back through one 32-bit bus word
  if (PC_W < 1 || PC_W > 32) begin : g_bad_pc_w
    $error("spm_top: PC_W must be 1..32");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  // bus channel state
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_nxt, awready_nxt, wready_nxt, arready_nxt, rvalid_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  // register file
  logic [NP-1:0] func_r, func_nxt, dir_r, dir_nxt, dout_r, dout_nxt;
  logic [4:0] sysctl_r, sysctl_nxt;
  logic [11:0] action_r, action_nxt;
  // pin side state
  logic [12:0] pin_q_r, pin_q_nxt, per_in_nxt;
  logic [1:0] qep_nxt;
  logic clk_sel_r, clk_sel_nxt;
  logic [5:0] cmp_r, cmp_nxt;
  logic cmp_oe_r, cmp_oe_nxt;
  logic taken_nxt, done_nxt;
  spm_exec_t exec_r, exec_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [NP-1:0] cell_out, cell_oe;
  logic do_write;
  logic pdp_trip;
  logic [31:0] wval;

  assign do_write = aw_ok_r && w_ok_r && !s_axi_bvalid;
  assign pdp_trip = sysctl_r[`SPM_SC_PDP_EN] && !power_drive_protect_input_n;

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == `SPM_OFF_FUNC) v[NP-1:0] = func_r;
    else if (a == `SPM_OFF_DIR) v[NP-1:0] = dir_r;
    else if (a == `SPM_OFF_DOUT) v[NP-1:0] = dout_r;
    else if (a == `SPM_OFF_PIN) v[12:0] = pin_q_r;
    else if (a == `SPM_OFF_SYSCTL) v[4:0] = sysctl_r;
    else if (a == `SPM_OFF_STATUS) v[3:0] = {exec_r == SPM_RUN, pdp_trip, cmp_oe_r,
                                             pin_q_r[`SPM_P_BRANCH]};
    else if (a == `SPM_OFF_ACTION) v[11:0] = action_r;
    else if (a == `SPM_OFF_PC) v[PC_W-1:0] = pc_r;
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= `SPM_OFF_PC;
  endfunction

  // axi4-lite slave; one write and one read in flight, read answered on the edge that takes it, write one cycle later
  always_comb begin
    aw_ok_nxt = aw_ok_r;
    aw_addr_nxt = aw_addr_r;
    w_ok_nxt = w_ok_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = s_axi_bvalid;
    bresp_nxt = s_axi_bresp;
    arready_nxt = s_axi_arready;
    rvalid_nxt = s_axi_rvalid;
    rresp_nxt = s_axi_rresp;
    rdata_nxt = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_ok_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(aw_addr_r) ? 2'b00 : 2'b10;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_word(s_axi_araddr);
      rresp_nxt = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    // take no new address or data until the pending write has been answered
    awready_nxt = !aw_ok_nxt && !bvalid_nxt;
    wready_nxt = !w_ok_nxt && !bvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_ok_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      aw_ok_r <= aw_ok_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_ok_r <= w_ok_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready <= wready_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_arready <= (!s_axi_arready && !s_axi_rvalid) ? 1'b1 : arready_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rresp <= rresp_nxt;
      s_axi_rdata <= rdata_nxt;
    end
  end

  // register file; the general reset reloads all but the clock output function
  always_comb begin
    func_nxt = func_r;
    dir_nxt = dir_r;
    dout_nxt = dout_r;
    sysctl_nxt = sysctl_r;
    action_nxt = action_r;
    wval = 32'h0000_0000;
    if (do_write) begin
      wval = merge(rd_word(aw_addr_r), w_data_r, w_strb_r);
      if (aw_addr_r == `SPM_OFF_FUNC) func_nxt = wval[NP-1:0];
      else if (aw_addr_r == `SPM_OFF_DIR) dir_nxt = wval[NP-1:0];
      else if (aw_addr_r == `SPM_OFF_DOUT) dout_nxt = wval[NP-1:0];
      else if (aw_addr_r == `SPM_OFF_SYSCTL) sysctl_nxt = wval[4:0];
      else if (aw_addr_r == `SPM_OFF_ACTION) action_nxt = wval[11:0];
    end
    if (!reset_input_pin_n) begin
      // cap, serial pins to inputs; flag and branch functions on
      func_nxt = `SPM_FUNC_GEN | (func_r & (13'h0001 << `SPM_P_CLOCK_OUTPUT_PIN));
      dir_nxt = '0;
      dout_nxt = '0;
      sysctl_nxt = `SPM_SYSCTL_RST;
      action_nxt = `SPM_ACTION_RST;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_r <= `SPM_FUNC_POR;
      dir_r <= '0;
      dout_r <= '0;
      sysctl_r <= `SPM_SYSCTL_RST;
      action_r <= `SPM_ACTION_RST;
    end else begin
      func_r <= func_nxt;
      dir_r <= dir_nxt;
      dout_r <= dout_nxt;
      sysctl_r <= sysctl_nxt;
      action_r <= action_nxt;
    end
  end

  // peripheral drive per pin; flag always drives, branch pin never does
  logic [12:0] per_out_m, per_oe_m;
  always_comb begin
    per_out_m = periph_out;
    per_oe_m = periph_oe;
    per_out_m[`SPM_P_FLAG] = sysctl_r[`SPM_SC_FLAG];
    per_oe_m[`SPM_P_FLAG] = 1'b1;
    per_oe_m[`SPM_P_BRANCH] = 1'b0;
    per_out_m[`SPM_P_CLOCK_OUTPUT_PIN] = clk_sel_r;
    per_oe_m[`SPM_P_CLOCK_OUTPUT_PIN] = 1'b1;
    for (int i = 0; i <= `SPM_P_CAP4; i++) begin
      per_oe_m[i] = 1'b0;
    end
    per_oe_m[`SPM_P_RXD] = 1'b0;
  end

  for (genvar g = 0; g < NP; g++) begin : g_cell
    spm_pin_cell u_cell (
      .aclk(aclk),
      .aresetn(aresetn && reset_input_pin_n),
      .fn(func_r[g]),
      .dir(dir_r[g]),
      .dout(dout_r[g]),
      .per_out(per_out_m[g]),
      .per_oe(per_oe_m[g]),
      .pin_out(cell_out[g]),
      .pin_oe(cell_oe[g])
    );
  end
  assign shared_pin_out = cell_out;
  assign shared_pin_oe = cell_oe;

  // input routing, compare qualification, branch decision
  always_comb begin
    pin_q_nxt = shared_pin_in;
    per_in_nxt = pin_q_r & func_r;
    qep_nxt = 2'b00;
    if (sysctl_r[`SPM_SC_QEP_EN]) begin
      qep_nxt = pin_q_r[1:0] & func_r[1:0];
      per_in_nxt[1:0] = 2'b00;
    end
    // clock source 0 is the processor clock after power-on
    clk_sel_nxt = clock_sources[sysctl_r[`SPM_SC_CLOCK_OUTPUT_SOURCE_SELECT_LO +: 2]];
    for (int i = 0; i < 6; i++) begin
      case (action_r[2*i +: 2])
        SPM_ACT_LOW: cmp_nxt[i] = 1'b0;
        SPM_ACT_ALOW: cmp_nxt[i] = !compare_level[i];
        SPM_ACT_AHIGH: cmp_nxt[i] = compare_level[i];
        default: cmp_nxt[i] = 1'b1;
      endcase
    end
    cmp_oe_nxt = reset_input_pin_n;
    taken_nxt = branch_poll && !shared_pin_in[`SPM_P_BRANCH];
    done_nxt = branch_poll;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q_r <= '0;
      periph_in <= '0;
      quadrature_encoder_input <= 2'b00;
      clk_sel_r <= 1'b0;
      cmp_r <= '0;
      cmp_oe_r <= 1'b0;
      branch_taken <= 1'b0;
      branch_done <= 1'b0;
    end else begin
      pin_q_r <= pin_q_nxt;
      periph_in <= per_in_nxt;
      quadrature_encoder_input <= qep_nxt;
      clk_sel_r <= clk_sel_nxt;
      cmp_r <= cmp_nxt;
      cmp_oe_r <= cmp_oe_nxt;
      branch_taken <= taken_nxt;
      branch_done <= done_nxt;
    end
  end

  assign full_compare_output = cmp_r;
  // the float must not wait for a clock edge, so the enable is gated after the flop
  assign full_compare_oe = {6{cmp_oe_r && !pdp_trip && reset_input_pin_n}};

  // execution control: halted with pc zero in reset, fetch from zero on release
  always_comb begin
    exec_nxt = exec_r;
    pc_nxt = pc_r;
    case (exec_r)
      SPM_HALT: begin
        pc_nxt = '0;
        exec_nxt = SPM_RUN;
      end
      SPM_RUN: begin
        if (fetch_advance) pc_nxt = pc_r + 1'b1;
      end
      default: exec_nxt = SPM_HALT;
    endcase
    if (!reset_input_pin_n) begin
      exec_nxt = SPM_HALT;
      pc_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_r <= SPM_HALT;
      pc_r <= '0;
    end else begin
      exec_r <= exec_nxt;
      pc_r <= pc_nxt;
    end
  end

  assign fetch_addr = pc_r;
  assign fetch_en = (exec_r == SPM_RUN);
endmodule
`default_nettype wire

// ===== spm_params.svh
/*
  register offsets, field positions, reset values for the shared pin block.
  assumes inclusion by bare name from the package and the top module.
*/
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH

`define SPM_NPIN 13
// pin indices into the shared pin vectors
`define SPM_P_CAP1 0
`define SPM_P_CAP2 1
`define SPM_P_CAP3 2
`define SPM_P_CAP4 3
`define SPM_P_FLAG 4
`define SPM_P_BRANCH 5
`define SPM_P_CLOCK_OUTPUT_PIN 6
`define SPM_P_TXD 7
`define SPM_P_RXD 8
`define SPM_P_MOSI 9
`define SPM_P_MISO 10
`define SPM_P_SCLK 11
`define SPM_P_STE 12

`define SPM_OFF_FUNC 8'h00
`define SPM_OFF_DIR 8'h04
`define SPM_OFF_DOUT 8'h08
`define SPM_OFF_PIN 8'h0C
`define SPM_OFF_SYSCTL 8'h10
`define SPM_OFF_STATUS 8'h14
`define SPM_OFF_ACTION 8'h18
`define SPM_OFF_PC 8'h1C

// sysctl fields
`define SPM_SC_CLOCK_OUTPUT_SOURCE_SELECT_LO 0
`define SPM_SC_FLAG 2
`define SPM_SC_PDP_EN 3
`define SPM_SC_QEP_EN 4

`define SPM_FUNC_POR 13'h0070
`define SPM_FUNC_GEN 13'h0030
`define SPM_SYSCTL_RST 5'h08
`define SPM_ACTION_RST 12'h000

`endif

// ===== spm_pkg.sv
/*
  types shared by the shared pin block.
  assumes spm_params.svh on the include path.
*/
`default_nettype none
package spm_pkg;
  `include "spm_params.svh"
  typedef enum logic [1:0] {
    SPM_ACT_LOW = 2'b00,
    SPM_ACT_ALOW = 2'b01,
    SPM_ACT_AHIGH = 2'b10,
    SPM_ACT_HIGH = 2'b11
  } spm_action_t;
  typedef enum logic [1:0] {
    SPM_HALT = 2'b01,
    SPM_RUN = 2'b10
  } spm_exec_t;
endpackage
`default_nettype wire

// ===== spm_pin_cell.sv
/*
  one shared pin: chooses between its peripheral and bit i/o, registered.
  assumes fn, dir and dout come from the register file of the top module.
*/
`default_nettype none
module spm_pin_cell (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fn,
  input wire logic dir,
  input wire logic dout,
  input wire logic per_out,
  input wire logic per_oe,
  output logic pin_out,
  output logic pin_oe
);
  logic out_nxt;
  logic oe_nxt;

  always_comb begin
    out_nxt = fn ? per_out : dout;
    oe_nxt = fn ? per_oe : dir;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= out_nxt;
      pin_oe <= oe_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== spm_top_props.sv
/*
  port assertions for the shared pin block, bound onto spm_top.
  assumes the protection unmask bit keeps its reset value of one.
*/
`default_nettype none
module spm_top_props #(
  parameter int PC_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_input_pin_n,
  input wire logic power_drive_protect_input_n,
  input wire logic [12:0] shared_pin_in,
  input wire logic [12:0] shared_pin_oe,
  input wire logic branch_poll,
  input wire logic branch_taken,
  input wire logic branch_done,
  input wire logic [PC_W-1:0] fetch_addr,
  input wire logic fetch_en,
  input wire logic [5:0] full_compare_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_cmp_rst_float:
    assert property (!reset_input_pin_n |-> full_compare_oe == 6'h00)
    else $error("compare outputs driven during reset");
  chk_cmp_trip_float:
    assert property (!power_drive_protect_input_n |-> full_compare_oe == 6'h00)
    else $error("compare outputs driven during protection trip");
  chk_pc_hold_rst:
    assert property (!reset_input_pin_n |=> fetch_addr == '0 && !fetch_en)
    else $error("execution not halted at zero in reset");
  chk_fetch_start:
    assert property ($rose(reset_input_pin_n) |-> ##[0:2] (fetch_en && fetch_addr == '0))
    else $error("fetch did not start at zero");
  chk_pins_rst_in:
    assert property (!reset_input_pin_n [*2] |-> shared_pin_oe == 13'h0000)
    else $error("shared pin driven during reset");
  chk_branch_answer:
    assert property (branch_poll |=> branch_done && branch_taken == !$past(shared_pin_in[5]))
    else $error("branch answer wrong");
  chk_branch_pulse:
    assert property (!branch_poll |=> !branch_done && !branch_taken)
    else $error("branch answer without poll");
  chk_flag_after_rst:
    assert property ($rose(reset_input_pin_n) |-> ##[1:3] (shared_pin_oe[4] && !shared_pin_oe[5]))
    else $error("flag or branch pin function wrong after reset");
  cov_taken: cover property (branch_poll ##1 branch_taken);
  cov_trip: cover property ($fell(power_drive_protect_input_n));
  cov_rst: cover property ($rose(reset_input_pin_n));
endmodule
bind spm_top spm_top_props #(.PC_W(PC_W)) spm_top_props_inst (.aclk, .aresetn,
  .reset_input_pin_n, .power_drive_protect_input_n, .shared_pin_in, .shared_pin_oe,
  .branch_poll, .branch_taken, .branch_done, .fetch_addr, .fetch_en, .full_compare_oe);
`default_nettype wire

// ===== spm_board.sv
/*
  board around the shared pins: resolves each pin from device and board drive.
  assumes one clock; undriven pins without a pull wander every cycle.
*/
`default_nettype none
module spm_board (
  input wire logic aclk,
  input wire logic [12:0] pin_out,
  input wire logic [12:0] pin_oe,
  input wire logic [12:0] drv_val,
  input wire logic [12:0] drv_en,
  output logic [12:0] pin_in
);
  logic [12:0] float_r = 13'h0000;
  // floating lines must not look like a stable level
  always_ff @(posedge aclk) float_r <= ~float_r;
  always_comb begin
    pin_in = float_r;
    for (int i = 0; i < 13; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (drv_en[i]) pin_in[i] = drv_val[i];
      else if (i == 5) pin_in[i] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== spm_tb_top.sv
/*
  self-checking bench for the shared pin block.
  assumes spm_board as the pin partner and the axi4-lite map of the block.
*/
`default_nettype none
`include "spm_params.svh"
module spm_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, branch_poll = 1'b0;
  logic reset_input_pin_n = 1'b1, power_drive_protect_input_n = 1'b1, fetch_advance = 1'b0;
  logic [12:0] periph_out = 13'h0a5a, periph_oe = 13'h0000, drv_val = 13'h1555;
  logic [12:0] drv_en = 13'h1fff;
  logic [3:0] clock_sources = 4'ha;
  logic [5:0] compare_level = 6'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic branch_taken, branch_done, fetch_en;
  logic [1:0] s_axi_bresp, s_axi_rresp, quadrature_encoder_input;
  logic [31:0] s_axi_rdata;
  logic [12:0] shared_pin_in, shared_pin_out, shared_pin_oe, periph_in;
  logic [15:0] fetch_addr;
  logic [5:0] full_compare_output, full_compare_oe;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  spm_top #(.PC_W(16)) spm_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_input_pin_n,
    .power_drive_protect_input_n, .shared_pin_in, .shared_pin_out, .shared_pin_oe, .periph_out,
    .periph_oe, .periph_in, .quadrature_encoder_input, .clock_sources, .branch_poll,
    .branch_taken, .branch_done, .fetch_advance, .fetch_addr, .fetch_en, .compare_level,
    .full_compare_output, .full_compare_oe);
  spm_board spm_board_inst (.aclk, .pin_out(shared_pin_out), .pin_oe(shared_pin_oe),
    .drv_val, .drv_en, .pin_in(shared_pin_in));
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, er);
    if (er == 2'b00) chk("rdata", s_axi_rdata, exp);
  endtask
  task automatic t_defaults;
    rdr(`SPM_OFF_FUNC, 32'h0000_0070, 2'b00);
    rdr(`SPM_OFF_DIR, 32'h0000_0000, 2'b00);
    rdr(`SPM_OFF_SYSCTL, 32'h0000_0008, 2'b00);
    rdr(8'h20, 32'h0000_0000, 2'b10);
    wr(8'h40, 32'h0000_ffff, 2'b10);
    chk("pin_oe", shared_pin_oe, 13'h0050);
    chk("flag", shared_pin_out[4], 1'b0);
    $display("test defaults done");
  endtask
  task automatic t_flag;
    wr(`SPM_OFF_SYSCTL, 32'h0000_000c, 2'b00);
    cyc(2);
    chk("flag_set", shared_pin_out[4], 1'b1);
    wr(`SPM_OFF_SYSCTL, 32'h0000_0008, 2'b00);
    cyc(2);
    chk("flag_clr", shared_pin_out[4], 1'b0);
    $display("test flag done");
  endtask
  task automatic t_clock_out;
    for (int s = 0; s < 4; s++) begin
      wr(`SPM_OFF_SYSCTL, 32'h0000_0008 | 32'(s), 2'b00);
      cyc(3);
      chk("clk_a", shared_pin_out[6], clock_sources[s]);
      @(posedge aclk);
      clock_sources <= ~clock_sources;
      cyc(3);
      chk("clk_b", shared_pin_out[6], clock_sources[s]);
    end
    $display("test clock_out done");
  endtask
  task automatic t_bit_io;
    wr(`SPM_OFF_FUNC, 32'h0000_0000, 2'b00);
    wr(`SPM_OFF_DIR, 32'h0000_1fff, 2'b00);
    wr(`SPM_OFF_DOUT, 32'h0000_0aaa, 2'b00);
    cyc(2);
    chk("oe_out", shared_pin_oe, 13'h1fff);
    chk("dout", shared_pin_out, 13'h0aaa);
    chk("per_in", periph_in, 13'h0000);
    wr(`SPM_OFF_DIR, 32'h0000_0000, 2'b00);
    cyc(3);
    chk("oe_in", shared_pin_oe, 13'h0000);
    rdr(`SPM_OFF_PIN, 32'h0000_1555, 2'b00);
    $display("test bit_io done");
  endtask
  task automatic t_function;
    wr(`SPM_OFF_FUNC, 32'h0000_1fff, 2'b00);
    wr(`SPM_OFF_SYSCTL, 32'h0000_0018, 2'b00);
    @(posedge aclk);
    periph_oe <= 13'h1fff;
    cyc(3);
    chk("oe_fn", shared_pin_oe, 13'h1ed0);
    chk("out_fn", shared_pin_out & 13'h1e80, 13'h0a5a & 13'h1e80);
    // encoder enabled: capture one and two go to the encoder, not the capture units
    chk("in_fn", periph_in & 13'h012f, 13'h1555 & 13'h012c);
    chk("qep", quadrature_encoder_input, drv_val[1:0]);
    @(posedge aclk);
    periph_oe <= 13'h0000;
    wr(`SPM_OFF_SYSCTL, 32'h0000_0008, 2'b00);
    $display("test function done");
  endtask
  task automatic poll(input logic exp);
    @(posedge aclk);
    branch_poll <= 1'b1;
    @(posedge aclk);
    branch_poll <= 1'b0;
    #1;
    chk("done", branch_done, 1'b1);
    chk("taken", branch_taken, exp);
    cyc(1);
    chk("pulse", branch_done, 1'b0);
  endtask
  task automatic t_branch;
    @(posedge aclk);
    drv_en <= 13'h0000;
    poll(1'b0);
    @(posedge aclk);
    drv_en <= 13'h0020;
    drv_val <= 13'h0000;
    poll(1'b1);
    $display("test branch done");
  endtask
  task automatic t_compare;
    logic [5:0] e;
    logic [1:0] md;
    wr(`SPM_OFF_ACTION, 32'h0000_09e4, 2'b00);
    @(posedge aclk);
    compare_level <= 6'h1a;
    cyc(3);
    for (int i = 0; i < 6; i++) begin
      md = 2'(12'h9e4 >> (2 * i));
      e[i] = (md == 2'b11) | (md == 2'b10 & compare_level[i]) | (md == 2'b01 & ~compare_level[i]);
    end
    chk("cmp_out", full_compare_output, e);
    chk("cmp_oe", full_compare_oe, 6'h3f);
    @(posedge aclk);
    power_drive_protect_input_n <= 1'b0;
    #1;
    chk("trip", full_compare_oe, 6'h00);
    @(posedge aclk);
    power_drive_protect_input_n <= 1'b1;
    cyc(3);
    chk("untrip", full_compare_oe, 6'h3f);
    $display("test compare done");
  endtask
  task automatic t_gen_reset;
    logic [15:0] pc0;
    // keep only the clock output function, which the general reset must not drop
    wr(`SPM_OFF_FUNC, 32'h0000_0040, 2'b00);
    wr(`SPM_OFF_DIR, 32'h0000_1fff, 2'b00);
    pc0 = fetch_addr;
    @(posedge aclk);
    fetch_advance <= 1'b1;
    repeat (5) @(posedge aclk);
    fetch_advance <= 1'b0;
    #1;
    chk("pc_run", fetch_addr, pc0 + 16'd5);
    @(posedge aclk);
    reset_input_pin_n <= 1'b0;
    #1;
    chk("rst_cmp", full_compare_oe, 6'h00);
    cyc(2);
    chk("rst_oe", shared_pin_oe, 13'h0000);
    chk("rst_pc", {fetch_en, fetch_addr}, 17'h0_0000);
    @(posedge aclk);
    reset_input_pin_n <= 1'b1;
    cyc(2);
    chk("run_pc", {fetch_en, fetch_addr}, 17'h1_0000);
    rdr(`SPM_OFF_FUNC, 32'h0000_0070, 2'b00);
    rdr(`SPM_OFF_DIR, 32'h0000_0000, 2'b00);
    rdr(`SPM_OFF_SYSCTL, 32'h0000_0008, 2'b00);
    rdr(`SPM_OFF_ACTION, 32'h0000_0000, 2'b00);
    rdr(`SPM_OFF_STATUS, 32'h0000_000a, 2'b00);
    chk("gen_oe", shared_pin_oe, 13'h0050);
    $display("test gen_reset done");
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_flag();
    t_clock_out();
    t_bit_io();
    t_function();
    t_branch();
    t_compare();
    t_gen_reset();
    finish_test();
  end
endmodule
`default_nettype wire
